// file: pkg/ocs_pkg.sv
`default_nettype none
package ocs_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int          CLK_PERIOD_NS      = 10;
   localparam int          CLK_TO_OUT_NS      = 20;
   localparam int          CLK_TO_OUT_CYC     = (CLK_TO_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0]  ALIGN_EDGES_ZERO   = 3'h5;
   localparam logic [2:0]  ALIGN_EDGES_OTHER  = 3'h4;
   // ----------------------------------------
   // Register map (index, byte address = 4 * index)
   // ----------------------------------------
   localparam logic [4:0]  EXT_CONFIG_IDX     = 5'h09;
   localparam logic [4:0]  OUTPUT_MODE_IDX    = 5'h10;
   localparam logic [4:0]  STATUS_IDX         = 5'h11;
   localparam logic [15:0] EXT_CONFIG_RESET   = 16'h03ff;
   localparam logic [2:0]  OUTPUT_MODE_RESET  = 3'h1;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int          PATTERN_EN_BIT     = 15;
   localparam int          TRIM_DISABLE_BIT   = 14;
   localparam int          DEMUX_BIT          = 0;
   localparam int          DDR_BIT            = 1;
   localparam int          EDGE_BIT           = 2;
   // ----------------------------------------
   // Held clock level, indexed by {ddr, edge}
   // ----------------------------------------
   localparam logic [3:0]  HELD_LEVEL_TABLE   = 4'h6;
   // ----------------------------------------
   // Test pattern words and complement masks
   // ----------------------------------------
   localparam logic [7:0]  WORD_DQ_DEMUX      = 8'h01;
   localparam logic [7:0]  WORD_DI_DEMUX      = 8'h02;
   localparam logic [7:0]  WORD_Q_DEMUX       = 8'h03;
   localparam logic [7:0]  WORD_I_DEMUX       = 8'h04;
   localparam logic [7:0]  WORD_Q_DIRECT      = 8'h01;
   localparam logic [7:0]  WORD_I_DIRECT      = 8'h02;
   localparam logic [9:0]  COMP_MASK_DEMUX    = 10'h00a;
   localparam logic [9:0]  COMP_MASK_DIRECT   = 10'h132;
   localparam logic [3:0]  SEQ_LEN_DEMUX      = 4'h5;
   localparam logic [3:0]  SEQ_LEN_DIRECT     = 4'ha;
   // ----------------------------------------
   // Output clock sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10
   } ocs_state_e;
endpackage : ocs_pkg
`default_nettype wire

// file: src/ocs_output_clock_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_output_clock_sync
(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        nrst_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // Sample clock and output clock reset pins
   input  wire logic        sample_clock_in,
   input  wire logic        output_clock_reset_in,
   // Converter core side
   input  wire logic        calibration_running_in,
   input  wire logic [7:0]  conv_delayed_q_in,
   input  wire logic [7:0]  conv_delayed_i_in,
   input  wire logic [7:0]  conv_q_in,
   input  wire logic [7:0]  conv_i_in,
   input  wire logic        conv_out_of_range_in,
   // Output ports
   output logic      [7:0]  delayed_q_port_out,
   output logic      [7:0]  delayed_i_port_out,
   output logic      [7:0]  q_port_out,
   output logic      [7:0]  i_port_out,
   output logic             out_of_range_out,
   output logic             forwarded_data_clock_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [1:0]                          samp_sync;
      logic                                samp_prev;
      logic [1:0]                          rst_sync;
      ocs_pkg::ocs_state_e                 state;
      logic [2:0]                          wait_cnt;
      logic                                div;
      logic [3:0]                          pat_idx;
      logic                                forwarded_data_clock_int;
      logic [ocs_pkg::CLK_TO_OUT_CYC-1:0]  forwarded_data_clock_dly;
      logic [15:0]                         ext_config;
      logic [2:0]                          out_mode;
      logic                                wr_pend;
      logic [4:0]                          wr_idx;
      logic [31:0]                         rdata;
      logic [7:0]                          dq;
      logic [7:0]                          di;
      logic [7:0]                          q;
      logic [7:0]                          i;
      logic                                oor;
   } ocs_state_s;

   ocs_state_s st_reg;
   ocs_state_s st_next;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic held_level(input logic [2:0] mode);
      held_level = ocs_pkg::HELD_LEVEL_TABLE[{mode[ocs_pkg::DDR_BIT],
                                              mode[ocs_pkg::EDGE_BIT]}];
   endfunction : held_level

   function automatic logic [2:0] align_edges(input logic [2:0] mode);
      if (mode[ocs_pkg::DEMUX_BIT] && mode[ocs_pkg::DDR_BIT] && !mode[ocs_pkg::EDGE_BIT])
         align_edges = ocs_pkg::ALIGN_EDGES_ZERO;
      else
         align_edges = ocs_pkg::ALIGN_EDGES_OTHER;
   endfunction : align_edges

   function automatic logic [7:0] pat_word(input logic [7:0] w, input logic comp);
      pat_word = comp ? ~w : w;
   endfunction : pat_word

   // ----------------------------------------
   // Combinational next state
   // ----------------------------------------
   logic       fall_en;
   logic       rst_act;
   logic       demux;
   logic       ddr;
   logic       freeze;
   logic       strobe;
   logic       comp;
   logic [3:0] seq_len;
   logic [4:0] a_idx;
   logic       a_valid;
   logic       restart;
   logic [3:0] cur_idx;

   always_comb
   begin
      st_next = st_reg;
      // ----------------------------------------
      // Synchronisers and edge detect
      // ----------------------------------------
      // Only the second stage of each synchroniser is read
      st_next.samp_sync = {st_reg.samp_sync[0], sample_clock_in};
      st_next.rst_sync  = {st_reg.rst_sync[0], output_clock_reset_in};
      st_next.samp_prev = st_reg.samp_sync[1];
      // Edge seen two clocks after the pin: the price of a clean sync
      fall_en = st_reg.samp_prev && !st_reg.samp_sync[1];
      rst_act = st_reg.rst_sync[1];
      demux   = st_reg.out_mode[ocs_pkg::DEMUX_BIT];
      ddr     = st_reg.out_mode[ocs_pkg::DDR_BIT];
      // Calibration may stop the clock; capture logic must not rely on it
      freeze  = calibration_running_in
                && !st_reg.ext_config[ocs_pkg::TRIM_DISABLE_BIT];
      seq_len = demux ? ocs_pkg::SEQ_LEN_DEMUX : ocs_pkg::SEQ_LEN_DIRECT;
      strobe  = 1'b0;
      restart = 1'b0;

      // ----------------------------------------
      // Output clock sequencer
      // ----------------------------------------
      unique case (st_reg.state)
         ocs_pkg::ST_HOLD:
         begin
            // Held level follows a mode write even while reset stands
            st_next.forwarded_data_clock_int = held_level(st_reg.out_mode);
            if (fall_en && !rst_act)
            begin
               st_next.state    = ocs_pkg::ST_WAIT;
               st_next.wait_cnt = align_edges(st_reg.out_mode);
            end
         end
         ocs_pkg::ST_WAIT:
         begin
            if (fall_en)
            begin
               if (st_reg.wait_cnt == 3'h1)
               begin
                  // Common phase for every device released together
                  st_next.state   = ocs_pkg::ST_RUN;
                  st_next.div     = 1'b0;
                  // Index restarts so released devices all begin on T0
                  restart         = 1'b1;
                  strobe          = 1'b1;
               end
               else
               begin
                  st_next.wait_cnt = st_reg.wait_cnt - 3'h1;
               end
            end
         end
         ocs_pkg::ST_RUN:
         begin
            if (fall_en)
            begin
               st_next.div = ~st_reg.div;
               strobe      = !demux || st_reg.div;
               if (freeze)
                  st_next.forwarded_data_clock_int = held_level(st_reg.out_mode);
               else if (!(demux && ddr) || st_reg.div)
                  st_next.forwarded_data_clock_int = ~st_reg.forwarded_data_clock_int;
            end
         end
         default:
         begin
            st_next.state = ocs_pkg::ST_HOLD;
         end
      endcase
      if (rst_act)
         st_next.state = ocs_pkg::ST_HOLD;

      // ----------------------------------------
      // Data ports: pattern or converted samples, one word per strobe
      // ----------------------------------------
      cur_idx = restart ? 4'h0 : st_reg.pat_idx;
      comp    = demux ? ocs_pkg::COMP_MASK_DEMUX[cur_idx]
                      : ocs_pkg::COMP_MASK_DIRECT[cur_idx];
      if (strobe)
      begin
         if (st_reg.ext_config[ocs_pkg::PATTERN_EN_BIT])
         begin
            if (demux)
            begin
               st_next.dq = pat_word(ocs_pkg::WORD_DQ_DEMUX, comp);
               st_next.di = pat_word(ocs_pkg::WORD_DI_DEMUX, comp);
               st_next.q  = pat_word(ocs_pkg::WORD_Q_DEMUX, comp);
               st_next.i  = pat_word(ocs_pkg::WORD_I_DEMUX, comp);
            end
            else
            begin
               st_next.dq = 8'h00;
               st_next.di = 8'h00;
               st_next.q  = pat_word(ocs_pkg::WORD_Q_DIRECT, comp);
               st_next.i  = pat_word(ocs_pkg::WORD_I_DIRECT, comp);
            end
            st_next.oor = comp;
         end
         else
         begin
            st_next.dq  = conv_delayed_q_in;
            st_next.di  = conv_delayed_i_in;
            st_next.q   = conv_q_in;
            st_next.i   = conv_i_in;
            st_next.oor = conv_out_of_range_in;
         end
         // A stale index past the end wraps rather than running on
         st_next.pat_idx = (cur_idx >= seq_len - 4'h1) ? 4'h0
                           : cur_idx + 4'h1;
      end

      // ----------------------------------------
      // Same fixed delay line on restart and in normal running
      // ----------------------------------------
      st_next.forwarded_data_clock_dly = {st_reg.forwarded_data_clock_dly[ocs_pkg::CLK_TO_OUT_CYC-2:0],
                          st_next.forwarded_data_clock_int};

      // ----------------------------------------
      // AHB-Lite data phase write
      // ----------------------------------------
      if (st_reg.wr_pend && st_reg.wr_idx == ocs_pkg::EXT_CONFIG_IDX)
         st_next.ext_config = hwdata_in[15:0];
      if (st_reg.wr_pend && st_reg.wr_idx == ocs_pkg::OUTPUT_MODE_IDX)
         st_next.out_mode = hwdata_in[2:0];

      // ----------------------------------------
      // AHB-Lite address phase
      // ----------------------------------------
      // Config register is write-only: its reads fall through to zero
      a_idx   = haddr_in[6:2];
      a_valid = hsel_in && htrans_in[1] && hready_in;
      st_next.wr_pend = a_valid && hwrite_in;
      st_next.wr_idx  = a_idx;
      st_next.rdata   = 32'h0000_0000;
      if (a_valid && !hwrite_in)
      begin
         if (a_idx == ocs_pkg::OUTPUT_MODE_IDX)
            st_next.rdata = {29'h0000_0000, st_reg.out_mode};
         else if (a_idx == ocs_pkg::STATUS_IDX)
            st_next.rdata = {24'h00_0000, st_reg.pat_idx,
                             st_reg.ext_config[ocs_pkg::PATTERN_EN_BIT],
                             st_reg.forwarded_data_clock_int, st_reg.state};
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_reg            <= '0;
         st_reg.state      <= ocs_pkg::ST_HOLD;
         st_reg.ext_config <= ocs_pkg::EXT_CONFIG_RESET;
         st_reg.out_mode   <= ocs_pkg::OUTPUT_MODE_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign hrdata_out               = st_reg.rdata;
   assign hreadyout_out            = 1'b1;
   assign hresp_out                = 1'b0;
   assign delayed_q_port_out       = st_reg.dq;
   assign delayed_i_port_out       = st_reg.di;
   assign q_port_out               = st_reg.q;
   assign i_port_out               = st_reg.i;
   assign out_of_range_out         = st_reg.oor;
   assign forwarded_data_clock_out = st_reg.forwarded_data_clock_dly[ocs_pkg::CLK_TO_OUT_CYC-1];

endmodule : ocs_output_clock_sync
`default_nettype wire

// file: testbench/ocs_capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_capture_model
(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        nrst_in,
   // Forwarded clock
   input  wire logic        forwarded_data_clock_in,
   output logic      [15:0] edge_count_out
);
   // ----------------------------------------
   // Capture clock edge counter
   // ----------------------------------------
   // Clock is only a capture strobe here, never a system clock
   logic last_reg;
   always_ff @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         last_reg       <= 1'b0;
         edge_count_out <= 16'h0;
      end
      else
      begin
         last_reg <= forwarded_data_clock_in;
         if (last_reg != forwarded_data_clock_in)
            edge_count_out <= edge_count_out + 16'h1;
      end
   end
endmodule : ocs_capture_model
`default_nettype wire

// file: testbench/ocs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_monitor
(
   // Clock, reset and bus
   input wire logic        clock_in,
   input wire logic        nrst_in,
   input wire logic        hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic        hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   // Link and output ports
   input wire logic        output_clock_reset_in,
   input wire logic [7:0]  delayed_q_port_out,
   input wire logic [7:0]  delayed_i_port_out,
   input wire logic [7:0]  q_port_out,
   input wire logic [7:0]  i_port_out,
   input wire logic        out_of_range_out,
   input wire logic        forwarded_data_clock_out
);
   // ----------------------------------------
   // Port checks
   // ----------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);
   wire logic rd_req = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
   a_ready_always: assert property (hreadyout_out) else $error("wait state seen");
   a_resp_okay: assert property (!hresp_out) else $error("error response seen");
   a_cfg_write_only: assert property (rd_req && haddr_in == 32'h24 |=> hrdata_out == 32'h0)
      else $error("config register readable");
   a_unmapped_zero: assert property (rd_req && haddr_in == 32'h3c |=> hrdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_held_stable: assert property ((output_clock_reset_in && !hsel_in)[*8]
      |-> $stable(forwarded_data_clock_out)) else $error("clock moved in reset");
   // Two cycles only: a reset landing just after a toggle may cut it short
   a_clock_spacing: assert property ($changed(forwarded_data_clock_out)
      && !output_clock_reset_in |=> $stable(forwarded_data_clock_out)[*2])
      else $error("clock toggled too fast");
   a_data_hold: assert property (output_clock_reset_in[*8] |-> $stable(q_port_out))
      else $error("data moved in reset");
   a_flag_comp: assert property (q_port_out == 8'hfc && i_port_out == 8'hfb
      |-> out_of_range_out && delayed_q_port_out == 8'hfe) else $error("bad complement word");
   a_flag_true: assert property (q_port_out == 8'h03 && i_port_out == 8'h04
      |-> !out_of_range_out && delayed_i_port_out == 8'h02) else $error("bad true word");
   a_direct_comp: assert property (q_port_out == 8'hfe && i_port_out == 8'hfd
      |-> out_of_range_out) else $error("bad direct flag");
   c_release: cover property ($fell(output_clock_reset_in));
   c_demux_comp: cover property (q_port_out == 8'hfc);
   c_direct_comp: cover property (q_port_out == 8'hfe && out_of_range_out);
endmodule : ocs_monitor
bind ocs_output_clock_sync ocs_monitor u_mon (.clock_in, .nrst_in, .hsel_in, .haddr_in,
   .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
   .output_clock_reset_in, .delayed_q_port_out, .delayed_i_port_out, .q_port_out,
   .i_port_out, .out_of_range_out, .forwarded_data_clock_out);
`default_nettype wire

// file: testbench/ocs_output_clock_sync_test.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_output_clock_sync_test;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        sclk = 1'b0;
   logic        ocr = 1'b0;
   logic        cal = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hrdy, hresp, oor, fdc;
   logic [7:0]  dq, di, qp, ip;
   logic [15:0] ecnt;
   int          n_mismatch = 0;
   int          checked = 0;
   int          nfall = 0;
   always #5 clk = ~clk;
   always #40 sclk = ~sclk;
   always @(negedge sclk) nfall++;
   ocs_output_clock_sync u_dut (.clock_in(clk), .nrst_in(nrst), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hresp), .sample_clock_in(sclk), .output_clock_reset_in(ocr),
      .calibration_running_in(cal), .conv_delayed_q_in(8'h5a), .conv_delayed_i_in(8'h5a),
      .conv_q_in(8'h5a), .conv_i_in(8'h5a), .conv_out_of_range_in(1'b0),
      .delayed_q_port_out(dq), .delayed_i_port_out(di), .q_port_out(qp), .i_port_out(ip),
      .out_of_range_out(oor), .forwarded_data_clock_out(fdc));
   ocs_capture_model u_cap (.clock_in(clk), .nrst_in(nrst), .forwarded_data_clock_in(fdc),
      .edge_count_out(ecnt));
   // ----------------------------------------
   // Shared tasks and scenarios
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (!hrdy);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (!hrdy);
      r = hrdata;
   endtask : bus
   task automatic regs;
      logic [31:0] r;
      // Reset held so the sequencer stays in hold for the status reads
      ocr <= 1'b1;
      bus(1'b0, 32'h24, 32'h0, r);
      check(r, 32'h0);
      bus(1'b0, 32'h3c, 32'h0, r);
      check(r, 32'h0);
      bus(1'b0, 32'h44, 32'h0, r);
      check(r[3:0], 4'h0);
      bus(1'b1, 32'h24, 32'h83ff, r);
      bus(1'b0, 32'h44, 32'h0, r);
      check(r[3], 1'b1);
      // Turned off again before the sequencer reaches its run state
      bus(1'b1, 32'h24, 32'h03ff, r);
   endtask : regs
   task automatic held_levels;
      logic [31:0] r;
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk);
         ocr <= 1'b1;
         bus(1'b1, 32'h40, {29'h0, m[0], m[1], 1'b1}, r);
         repeat (30) @(posedge clk);
         check(fdc, ocs_pkg::HELD_LEVEL_TABLE[m]);
      end
   endtask : held_levels
   task automatic release_count(input logic e, output int d);
      logic [31:0] r;
      logic        h;
      int          n0;
      @(posedge clk);
      ocr <= 1'b1;
      bus(1'b1, 32'h40, {29'h0, e, 2'b11}, r);
      repeat (30) @(posedge clk);
      h = fdc;
      @(posedge sclk);
      @(posedge clk);
      ocr <= 1'b0;
      n0 = nfall;
      for (int k = 0; k < 300 && fdc === h; k++) @(posedge clk);
      d = nfall - n0;
   endtask : release_count
   task automatic align;
      int d0, d1;
      release_count(1'b0, d0);
      release_count(1'b1, d1);
      check(d0 - d1, 1);
      check(d1 >= 5, 1'b1);
   endtask : align
   task automatic pattern(input logic [31:0] cfg, input logic [2:0] mode);
      logic [31:0] r;
      logic [0:9]  cm;
      logic [7:0]  t;
      cm = mode[0] ? 10'b0101001010 : 10'b0100110010;
      t = mode[0] ? 8'h03 : 8'h01;
      @(posedge clk);
      ocr <= 1'b1;
      bus(1'b1, 32'h40, {29'h0, mode}, r);
      bus(1'b1, 32'h24, cfg, r);
      @(posedge clk);
      ocr <= 1'b0;
      for (int k = 0; k < 40 && qp !== t; k++) @(negedge sclk);
      for (int w = 0; w < 10; w++)
      begin
         check(qp, t ^ {8{cm[w]}});
         check(ip, (t + 8'h1) ^ {8{cm[w]}});
         check(oor, cm[w]);
         if (mode[0])
         begin
            check(dq, (t - 8'h2) ^ {8{cm[w]}});
            check(di, (t - 8'h1) ^ {8{cm[w]}});
         end
         repeat (mode[0] ? 2 : 1) @(negedge sclk);
      end
   endtask : pattern
   task automatic calib;
      logic [31:0] r;
      int          e0;
      for (int t = 0; t < 2; t++)
      begin
         bus(1'b1, 32'h24, t ? 32'h43ff : 32'h03ff, r);
         @(posedge clk);
         cal <= 1'b1;
         repeat (20) @(posedge clk);
         e0 = ecnt;
         repeat (80) @(posedge clk);
         check(ecnt != e0, t[0]);
         check(qp, 8'h5a);
         @(posedge clk);
         cal <= 1'b0;
      end
   endtask : calib
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      regs();
      held_levels();
      align();
      pattern(32'h83ff, 3'h1);
      pattern(32'h83ff, 3'h0);
      pattern(32'ha3ff, 3'h3);
      calib();
      final_report();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule : ocs_output_clock_sync_test
`default_nettype wire
